// *** core/brte_pkg.sv ***
// shared constants and types of the boundary-run test engine
package brte_pkg;
    // cell counts of the boundary cell chain
    localparam int CELLS_W = 40;
    localparam int HALF_W = 20;
    localparam int CTL_W = 12;
    localparam int CTL_LSB = 36;
    localparam int OE_A_POS = 46;
    localparam int OE_B_POS = 47;
    localparam int PIN_W = 20;
    localparam int CNT_W = 16;

    // run-test instruction code
    localparam logic [7:0] INSTR_RUN_TEST = 8'h09;

    // opcode values of the test control register
    localparam logic [1:0] OPLO_TOGGLE = 2'h0;
    localparam logic [1:0] OPLO_PSEUDO_RANDOM_GENERATION = 2'h1;
    localparam logic [1:0] OPLO_PSA = 2'h2;
    localparam logic [1:0] OPLO_COMBINED = 2'h3;

    // feedback taps per generator length
    localparam logic [39:0] TAPS40 = 40'ha0_0014_0000;
    localparam logic [19:0] TAPS20 = 20'h9_0000;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CELLS_LO = 8'h04;
    localparam logic [7:0] OFS_CELLS_HI = 8'h08;
    localparam logic [7:0] OFS_CTL_CELLS = 8'h0c;
    localparam logic [7:0] OFS_SHADOW_LO = 8'h10;
    localparam logic [7:0] OFS_SHADOW_HI = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // field positions
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_INSTR_LSB = 8;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_MODE_LSB = 1;
    localparam int STAT_DIR_BIT = 4;
    localparam int STAT_CNT_LSB = 16;

    // reset values
    localparam logic [2:0] OPCODE_RST = 3'h0;
    localparam logic [7:0] INSTR_RST = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // decoded operation
    typedef enum logic [2:0] {
        MODE_TOGGLE,
        MODE_PRPG40,
        MODE_PSA40,
        MODE_SIGNATURE_PLUS_PATTERN,
        MODE_SIGNATURE_PLUS_COUNT
    } brte_mode_e;
endpackage

// *** core/brte_cells.sv ***
// next value of the shift elements for one rising test-clock edge
`timescale 1ns/100ps
module brte_cells #(
    parameter int W = brte_pkg::CELLS_W,
    parameter int H = brte_pkg::HALF_W
) (
    // operation and direction
    input brte_pkg::brte_mode_e mode,
    input wire logic a_to_b,
    // cell state and pin levels
    input wire logic [W-1:0] in_mask,
    input wire logic [W-1:0] cells,
    input wire logic [W-1:0] pins,
    // result
    output logic [W-1:0] cells_next
);
    // mirror a vector so the generators run the other way
    function automatic logic [W-1:0] mirror(input logic [W-1:0] v);
        logic [W-1:0] r;
        r = '0;
        for (int i = 0; i < W; i++) begin
            r[i] = v[W-1-i];
        end
        return r;
    endfunction

    // full-length feedback shift step
    function automatic logic [W-1:0] step_full(input logic [W-1:0] v);
        return {v[W-2:0], ^(v & brte_pkg::TAPS40)};
    endfunction

    // half-length feedback shift step
    function automatic logic [H-1:0] step_half(input logic [H-1:0] v);
        return {v[H-2:0], ^(v & brte_pkg::TAPS20)};
    endfunction

    logic [W-1:0] o;
    logic [W-1:0] p;
    logic [W-1:0] m;
    logic [W-1:0] n;

    // direction picks the orientation; low half is always the input side
    assign o = a_to_b ? cells : mirror(cells);
    assign p = a_to_b ? pins : mirror(pins);
    assign m = a_to_b ? in_mask : mirror(in_mask);

    // an all-zero seed stays all zero in every xor generator
    always_comb begin
        n = o;
        unique case (mode)
            brte_pkg::MODE_TOGGLE: begin
                n = (m & p) | (~m & ~o);
            end
            brte_pkg::MODE_PRPG40: begin
                n = step_full(o);
            end
            brte_pkg::MODE_PSA40: begin
                n = step_full(o) ^ (p & m);
            end
            brte_pkg::MODE_SIGNATURE_PLUS_PATTERN: begin
                n[H-1:0] = step_half(o[H-1:0]) ^ (p[H-1:0] & m[H-1:0]);
                n[W-1:H] = step_half(o[W-1:H]);
            end
            brte_pkg::MODE_SIGNATURE_PLUS_COUNT: begin
                n[H-1:0] = step_half(o[H-1:0]) ^ (p[H-1:0] & m[H-1:0]);
                n[W-1:H] = o[W-1:H] + 20'h0_0001;
            end
        endcase
    end

    assign cells_next = a_to_b ? n : mirror(n);
endmodule

// *** core/brte_top.sv ***
// boundary-run test engine with a classic wishbone register slave
// What this block does
// - opcode comes from control register bits 2 to 0, bit 2 most significant.
// - operate only with run-test instruction loaded and in Run-Test/Idle.
// - low bits 00 select sample-and-toggle regardless of bit 2.
// - low bits 01 select 40-bit pseudo-random pattern generation.
// - low bits 10 select 40-bit signature compression.
// - opcode 011 selects 20-bit signature plus 20-bit pseudo-random pattern.
// - opcode 111 selects 20-bit signature plus 20-bit binary count.
// - control cells 47 to 36 never take part in any algorithm.
// - enable cells 47 and 46 decide whether output pins drive.
// - run only when exactly one direction is enabled, else act as bypass.
// - sample-and-toggle captures input-mode pin levels each rising test clock.
// - toggle inverts output cells on rise, shadows and pins follow on fall.
// - pattern mode steps 40-bit generator on rise, shadows and pins on fall.
// - an all-zero seed keeps producing the same all-zero pattern.
// - 40-bit signature folds input-mode pin levels in each rising edge.
// - 40-bit signature mode holds shadows and keeps driving them.
// - combined modes compress inputs into 20-bit signature in input cells.
// - signature-plus-pattern steps 20-bit generator in output cells, pins on fall.
// - signature-plus-count increments 20-bit counter in output cells, pins on fall.
// - instruction 00001001 is the run-test instruction, putting device in test mode.
`timescale 1ns/100ps
module brte_top #(
    parameter int CELLS = brte_pkg::CELLS_W,
    parameter int PINS = brte_pkg::PIN_W
) (
    // clock, reset and clock enable
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic CE,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // test access pins from the controller side
    input wire logic TCK,
    input wire logic RUN_IDLE,
    // direction enables, active low
    input wire logic A_TO_B_OUTPUT_ENABLE_N,
    input wire logic B_TO_A_OUTPUT_ENABLE_N,
    // a side i/o pins
    input wire logic [PINS-1:0] A_IN,
    output logic [PINS-1:0] A_OUT,
    output logic A_OE,
    // b side i/o pins
    input wire logic [PINS-1:0] B_IN,
    output logic [PINS-1:0] B_OUT,
    output logic B_OE,
    // engine state
    output logic TEST_ACTIVE
);
    localparam int CW = brte_pkg::CTL_W;
    localparam int NW = brte_pkg::CNT_W;

    // every pin and the test clock cross into the system clock through
    // two flops; tck_d is the third stage, used only for edge detection
    // complete state of the block
    typedef struct packed {
        logic tck_s1;
        logic tck_s2;
        logic tck_d;
        logic idle_s1;
        logic idle_s2;
        logic a_to_b_output_enable_n_s1;
        logic a_to_b_output_enable_n_s2;
        logic b_to_a_output_enable_n_s1;
        logic b_to_a_output_enable_n_s2;
        logic [PINS-1:0] pa_s1;
        logic [PINS-1:0] pa_s2;
        logic [PINS-1:0] pb_s1;
        logic [PINS-1:0] pb_s2;
        logic [2:0] opcode;
        logic [7:0] instr;
        logic [CELLS-1:0] cells;
        logic [CW-1:0] ctl_cells;
        logic [CELLS-1:0] shadow;
        logic [NW-1:0] step_cnt;
        brte_pkg::brte_mode_e mode;
        logic run;
        logic a_oe;
        logic b_oe;
        logic ack;
        logic [31:0] dat;
    } brte_state_s;

    brte_state_s st_reg;
    brte_state_s st_next;

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = wdat[8*b +: 8];
            end
        end
        return r;
    endfunction

    // opcode to operation decode
    function automatic brte_pkg::brte_mode_e decode_op(input logic [2:0] op);
        brte_pkg::brte_mode_e md;
        md = brte_pkg::MODE_TOGGLE;
        unique case (op[1:0])
            brte_pkg::OPLO_TOGGLE: md = brte_pkg::MODE_TOGGLE;
            brte_pkg::OPLO_PSEUDO_RANDOM_GENERATION: md = brte_pkg::MODE_PRPG40;
            brte_pkg::OPLO_PSA: md = brte_pkg::MODE_PSA40;
            brte_pkg::OPLO_COMBINED: begin
                md = op[2] ? brte_pkg::MODE_SIGNATURE_PLUS_COUNT
                           : brte_pkg::MODE_SIGNATURE_PLUS_PATTERN;
            end
        endcase
        return md;
    endfunction

    // decoded conditions from the current state
    logic tck_rise;
    logic tck_fall;
    logic a_to_b;
    logic one_dir;
    logic run_ok;
    logic a_in_mode;
    logic b_in_mode;
    brte_pkg::brte_mode_e mode_now;
    logic [CELLS-1:0] in_mask;
    logic [CELLS-1:0] pins_now;
    logic [CELLS-1:0] cells_step;
    logic [31:0] wr_val;
    logic [31:0] rd_val;
    logic bus_req;

    // synchroniser flops reset low like an idle test clock, so no false
    // edge appears after reset
    // edges of the synchronised test clock
    assign tck_rise = st_reg.tck_s2 & ~st_reg.tck_d;
    assign tck_fall = ~st_reg.tck_s2 & st_reg.tck_d;

    // direction and run qualification
    assign a_to_b = ~st_reg.a_to_b_output_enable_n_s2 & st_reg.b_to_a_output_enable_n_s2;
    assign one_dir = st_reg.a_to_b_output_enable_n_s2 ^ st_reg.b_to_a_output_enable_n_s2;
    assign run_ok = (st_reg.instr == brte_pkg::INSTR_RUN_TEST)
                    & st_reg.idle_s2 & one_dir;
    assign mode_now = decode_op(st_reg.opcode);

    // enable cells are active low: an inactive one leaves its side as inputs
    assign a_in_mode = st_reg.ctl_cells[brte_pkg::OE_A_POS -
                                        brte_pkg::CTL_LSB];
    assign b_in_mode = st_reg.ctl_cells[brte_pkg::OE_B_POS -
                                        brte_pkg::CTL_LSB];
    assign in_mask = {{PINS{b_in_mode}}, {PINS{a_in_mode}}};
    assign pins_now = {st_reg.pb_s2, st_reg.pa_s2};

    // in the 20-bit modes the source side of the enabled direction holds
    // the signature and the other side the generator or counter; the
    // sub-module mirrors the chain for b-to-a so one set of taps serves
    // shift-element update for one rising edge
    brte_cells #(
        .W(CELLS),
        .H(brte_pkg::HALF_W)
    ) u_cells (
        .mode(mode_now),
        .a_to_b(a_to_b),
        .in_mask(in_mask),
        .cells(st_reg.cells),
        .pins(pins_now),
        .cells_next(cells_step)
    );

    // a request is taken only while ack is low, so each gets one ack
    // bus request and unmerged write data
    assign bus_req = WB_CYC_I & WB_STB_I & ~st_reg.ack;
    assign wr_val = WB_DAT_I;

    // register map, byte offsets:
    //   00 control: opcode in [2:0], loaded instruction in [15:8];
    //      a write here also clears the step count
    //   04 data cells 31 to 0, read and write
    //   08 data cells 39 to 32 in [7:0], read and write
    //   0c chain positions 47 to 36 in [11:0], read and write;
    //      bit 11 is the b side enable cell, bit 10 the a side one,
    //      a zero in either puts that side in output mode
    //   10 shadow latches 31 to 0, read only
    //   14 shadow latches 39 to 32 in [7:0], read only
    //   18 status: [0] active, [3:1] operation, [4] a-to-b direction,
    //      [31:16] count of rising test-clock steps
    //   any other offset reads as zero and ignores writes
    // register read mux
    always_comb begin
        rd_val = brte_pkg::RD_ZERO;
        unique case (WB_ADR_I)
            brte_pkg::OFS_CTRL: begin
                rd_val[brte_pkg::CTRL_OP_LSB +: 3] = st_reg.opcode;
                rd_val[brte_pkg::CTRL_INSTR_LSB +: 8] = st_reg.instr;
            end
            brte_pkg::OFS_CELLS_LO: begin
                rd_val = st_reg.cells[31:0];
            end
            brte_pkg::OFS_CELLS_HI: begin
                rd_val[CELLS-33:0] = st_reg.cells[CELLS-1:32];
            end
            brte_pkg::OFS_CTL_CELLS: begin
                rd_val[CW-1:0] = st_reg.ctl_cells;
            end
            brte_pkg::OFS_SHADOW_LO: begin
                rd_val = st_reg.shadow[31:0];
            end
            brte_pkg::OFS_SHADOW_HI: begin
                rd_val[CELLS-33:0] = st_reg.shadow[CELLS-1:32];
            end
            brte_pkg::OFS_STATUS: begin
                rd_val[brte_pkg::STAT_RUN_BIT] = st_reg.run;
                rd_val[brte_pkg::STAT_MODE_LSB +: 3] = st_reg.mode;
                rd_val[brte_pkg::STAT_DIR_BIT] = a_to_b;
                rd_val[brte_pkg::STAT_CNT_LSB +: NW] = st_reg.step_cnt;
            end
            default: begin
                rd_val = brte_pkg::RD_ZERO; // unmapped reads as zero
            end
        endcase
    end

    // timing against the system clock: each test-clock phase must last
    // at least three system clocks; a rising test-clock edge reaches the
    // cells on the third system edge after it, a falling one reaches
    // shadows, pins and enables on the third edge too
    // bus timing: ack follows one cycle after the request is taken and
    // lasts one cycle; read data holds until the next request, a write returning zero
    // a bus write to the cells in the cycle of a step wins over the step
    // next-state logic
    always_comb begin
        logic [31:0] tmp;
        tmp = brte_pkg::RD_ZERO;
        st_next = st_reg;

        // two-flop synchronisers for the test clock, run-idle, enables and pins
        st_next.tck_s1 = TCK;
        st_next.tck_s2 = st_reg.tck_s1;
        st_next.tck_d = st_reg.tck_s2;
        st_next.idle_s1 = RUN_IDLE;
        st_next.idle_s2 = st_reg.idle_s1;
        st_next.a_to_b_output_enable_n_s1 = A_TO_B_OUTPUT_ENABLE_N;
        st_next.a_to_b_output_enable_n_s2 = st_reg.a_to_b_output_enable_n_s1;
        st_next.b_to_a_output_enable_n_s1 = B_TO_A_OUTPUT_ENABLE_N;
        st_next.b_to_a_output_enable_n_s2 = st_reg.b_to_a_output_enable_n_s1;
        st_next.pa_s1 = A_IN;
        st_next.pa_s2 = st_reg.pa_s1;
        st_next.pb_s1 = B_IN;
        st_next.pb_s2 = st_reg.pb_s1;

        // status view of the engine
        st_next.run = run_ok;
        st_next.mode = mode_now;

        // rising edge: shift elements take the selected algorithm's step;
        // control cells are kept out of every algorithm
        if (run_ok && tck_rise) begin
            st_next.cells = cells_step;
            st_next.step_cnt = st_reg.step_cnt + 16'h0001;
        end

        // falling edge: output-mode shadows follow their shift elements,
        // except in full-length signature mode where they hold
        if (run_ok && tck_fall &&
            mode_now != brte_pkg::MODE_PSA40) begin
            st_next.shadow = (st_reg.shadow & in_mask) |
                             (st_reg.cells & ~in_mask);
        end

        // when the engine is not qualified both sides are forced to float,
        // the same as under the bypass instruction
        // pin drive follows the enable cells while the engine runs
        if (tck_fall || !run_ok) begin
            st_next.a_oe = run_ok & ~a_in_mode;
            st_next.b_oe = run_ok & ~b_in_mode;
        end

        // wishbone: one registered ack per request, dropped next cycle
        st_next.ack = 1'b0;
        if (bus_req) begin
            st_next.ack = 1'b1;
            st_next.dat = rd_val;
            if (WB_WE_I) begin
                st_next.dat = brte_pkg::RD_ZERO;
                unique case (WB_ADR_I)
                    brte_pkg::OFS_CTRL: begin
                        tmp = merge(rd_val, wr_val, WB_SEL_I);
                        st_next.opcode = tmp[brte_pkg::CTRL_OP_LSB +: 3];
                        st_next.instr = tmp[brte_pkg::CTRL_INSTR_LSB +: 8];
                        st_next.step_cnt = '0;
                    end
                    brte_pkg::OFS_CELLS_LO: begin
                        tmp = merge(st_next.cells[31:0], wr_val, WB_SEL_I);
                        st_next.cells[31:0] = tmp;
                    end
                    brte_pkg::OFS_CELLS_HI: begin
                        tmp = merge(rd_val, wr_val, WB_SEL_I);
                        st_next.cells[CELLS-1:32] = tmp[CELLS-33:0];
                    end
                    brte_pkg::OFS_CTL_CELLS: begin
                        tmp = merge(rd_val, wr_val, WB_SEL_I);
                        st_next.ctl_cells = tmp[CW-1:0];
                    end
                    default: begin
                        tmp = brte_pkg::RD_ZERO; // read-only or unmapped
                    end
                endcase
            end
        end
    end

    // the reset branch loads constants only; opcode, instruction, cells
    // and shadows all start at zero
    // state register; clock enable low freezes everything
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_reg <= '0;
        end else if (CE) begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign WB_DAT_O = st_reg.dat;
    assign WB_ACK_O = st_reg.ack;
    assign A_OUT = st_reg.shadow[PINS-1:0];
    assign B_OUT = st_reg.shadow[CELLS-1:PINS];
    assign A_OE = st_reg.a_oe;
    assign B_OE = st_reg.b_oe;
    assign TEST_ACTIVE = st_reg.run;
endmodule

// *** tb/brte_tap_model.sv ***
// test controller model: drives the test clock and run-idle state
`timescale 1ns/100ps
module brte_tap_model (
    // test clock and tap state
    output logic tck,
    output logic run_idle
);
    // clock parked low, tap out of run-test/idle
    initial begin
        tck = 1'b0;
        run_idle = 1'b0;
    end
    // enter or leave run-test/idle
    task automatic idle(input logic v);
        run_idle <= v;
    endtask
    // n full clock periods, then the clock stands still low
    task automatic steps(input int n);
        #430;
        for (int i = 0; i < n; i++) begin
            tck = 1'b1;
            #400;
            tck = 1'b0;
            #400;
        end
    endtask
endmodule

// *** tb/brte_top_chk.sv ***
// bus and test-link assertions on the engine top ports
`timescale 1ns/100ps
module brte_top_chk #(
    parameter int PINS = brte_pkg::PIN_W
) (
    // clock, reset and bus
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // test link and pins
    input wire logic TCK,
    input wire logic RUN_IDLE,
    input wire logic A_TO_B_OUTPUT_ENABLE_N,
    input wire logic B_TO_A_OUTPUT_ENABLE_N,
    input wire logic [PINS-1:0] A_OUT,
    input wire logic A_OE,
    input wire logic [PINS-1:0] B_OUT,
    input wire logic B_OE,
    input wire logic TEST_ACTIVE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    // request taken by the slave at this edge
    sequence s_take;
        CE && WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    // falling test clock seen through the synchroniser
    sequence s_tck_fell;
        $past(TCK, 4) && !$past(TCK, 3);
    endsequence
    a_ack_answer: assert property (s_take |=> WB_ACK_O)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (WB_ACK_O && CE |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ack_idle: assert property (!WB_CYC_I |=> !WB_ACK_O)
        else $error("ack without request");
    a_unmapped_zero: assert property (
        (s_take and (!WB_WE_I && WB_ADR_I > 8'h18)) |=> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    a_pins_on_fall: assert property (
        !$stable({A_OUT, B_OUT}) |-> s_tck_fell)
        else $error("pins changed without falling test clock");
    a_active_needs_idle: assert property (
        $rose(TEST_ACTIVE) |-> $past(RUN_IDLE, 2))
        else $error("engine active outside run-test idle");
    a_bypass_no_drive: assert property (
        (A_TO_B_OUTPUT_ENABLE_N == B_TO_A_OUTPUT_ENABLE_N) [*6]
        |-> !TEST_ACTIVE && !A_OE && !B_OE)
        else $error("engine runs with equal direction enables");
    a_idle_low_off: assert property (
        !RUN_IDLE [*6] |-> !TEST_ACTIVE && !A_OE && !B_OE)
        else $error("engine active with run-idle low");
endmodule
bind brte_top brte_top_chk #(.PINS(PINS)) u_chk (.MCLK, .RESET_N, .CE,
    .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O,
    .TCK, .RUN_IDLE, .A_TO_B_OUTPUT_ENABLE_N, .B_TO_A_OUTPUT_ENABLE_N,
    .A_OUT, .A_OE, .B_OUT, .B_OE, .TEST_ACTIVE);

// *** tb/testbench.sv ***
// self-checking bench of the boundary-run test engine
`timescale 1ns/100ps
module testbench;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, tck, run_idle, a_oe, b_oe, active;
    logic ab_n = 1'b0;
    logic ba_n = 1'b1;
    logic [19:0] a_in = 20'h3c3c3;
    logic [19:0] b_in = 20'hc3c3c;
    logic [19:0] a_out, b_out;
    int err_total = 0;
    int checks_done = 0;
    // design and test controller model
    brte_top DUT (.MCLK(mclk), .RESET_N(reset_n), .CE(1'b1),
        .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .TCK(tck), .RUN_IDLE(run_idle),
        .A_TO_B_OUTPUT_ENABLE_N(ab_n), .B_TO_A_OUTPUT_ENABLE_N(ba_n),
        .A_IN(a_in), .A_OUT(a_out), .A_OE(a_oe), .B_IN(b_in),
        .B_OUT(b_out), .B_OE(b_oe), .TEST_ACTIVE(active));
    brte_tap_model ctl (.tck(tck), .run_idle(run_idle));
    always #50 mclk = ~mclk;
    // one classic bus cycle held until ack
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic cmp(input string nm, input logic [39:0] e,
        input logic [39:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // read the 40 data cells
    task automatic cells(output logic [39:0] c);
        logic [31:0] lo, hi;
        bus(1'b0, 8'h04, 32'h0, lo);
        bus(1'b0, 8'h08, 32'h0, hi);
        c = {hi[7:0], lo};
    endtask
    // seed chain, enable cells, then opcode and instruction
    task automatic setup(input logic [2:0] op, input logic [11:0] ce,
        input logic [39:0] s, input logic [7:0] ins);
        wr(8'h04, s[31:0]);
        wr(8'h08, {24'h0, s[39:32]});
        wr(8'h0c, {20'h0, ce});
        wr(8'h00, {16'h0, ins, 5'h0, op});
    endtask
    task automatic run(input int n);
        ctl.idle(1'b1);
        ctl.steps(n);
    endtask
    // reset values, unmapped and read-only places
    task automatic t_reset();
        logic [31:0] q;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0, q);
            cmp("reset reg", i == 6 ? 40'h10 : 40'h0, {8'h0, q});
        end
        wr(8'h1c, 32'hffff_ffff);
        wr(8'h10, 32'hffff_ffff);
        bus(1'b0, 8'h1c, 32'h0, q);
        cmp("unmapped", 40'h0, {8'h0, q});
        bus(1'b0, 8'h10, 32'h0, q);
        cmp("shadow ro", 40'h0, {8'h0, q});
        cmp("reset oe", 40'h0, {a_oe, b_oe, active});
    endtask
    // every opcode decodes to its operation
    task automatic t_decode();
        logic [31:0] q;
        logic [2:0] m[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h2, 3'h4};
        for (int op = 0; op < 8; op++) begin
            wr(8'h00, {16'h0, 8'h09, 5'h0, 3'(op)});
            bus(1'b0, 8'h18, 32'h0, q);
            cmp("mode", m[op], q[3:1]);
        end
    endtask
    // sample inputs and toggle outputs in one direction
    task automatic t_toggle(input logic ab);
        logic [39:0] s, c, e;
        logic [19:0] o;
        logic [31:0] q;
        s = 40'ha5_1234_5678;
        @(posedge mclk);
        ab_n <= ~ab;
        ba_n <= ab;
        setup(3'h4, ab ? 12'h400 : 12'h800, s, 8'h09);
        for (int i = 1; i <= 2; i++) begin
            run(1);
            o = ab ? s[39:20] : s[19:0];
            if (i == 1) o = ~o;
            e = ab ? {o, a_in} : {b_in, o};
            cells(c);
            cmp("toggle cells", e, c);
            cmp("toggle pins", o, ab ? b_out : a_out);
            cmp("oe", {ab, ~ab, 1'b1}, {b_oe, a_oe, active});
        end
        bus(1'b0, 8'h0c, 32'h0, q);
        cmp("ctl cells", ab ? 40'h400 : 40'h800, {8'h0, q});
    endtask
    // pattern generators: zero seed stays, live seed moves
    task automatic t_pseudo_random_generation();
        logic [39:0] c;
        for (int k = 0; k < 2; k++) begin
            setup(k ? 3'h3 : 3'h1, 12'h400, 40'h0, 8'h09);
            run(3);
            cells(c);
            cmp("zero seed", 40'h0, {c[39:20], k ? 20'h0 : c[19:0]});
            setup(k ? 3'h3 : 3'h1, 12'h400, 40'h00001_00001, 8'h09);
            run(2);
            cells(c);
            cmp("gen cells", 40'h4, c[39:20]);
            cmp("gen pins", 40'h4, b_out);
        end
    endtask
    // binary count wraps through zero
    task automatic t_count();
        logic [39:0] c;
        setup(3'h7, 12'h400, 40'hffffe_00000, 8'h09);
        run(3);
        cells(c);
        cmp("count cells", 40'h1, c[39:20]);
        cmp("count pins", 40'h1, b_out);
    endtask
    // signature mode moves cells, holds the driven shadow
    task automatic t_psa();
        logic [39:0] c;
        setup(3'h6, 12'h400, 40'h1, 8'h09);
        run(3);
        cells(c);
        cmp("psa moved", 40'h1, {39'h0, c != 40'h1});
        cmp("psa pins", {20'h1, 2'b10}, {b_out, b_oe, a_oe});
    endtask
    // no step with equal enables, other instruction or idle low
    task automatic t_bypass();
        logic [39:0] c, s;
        s = 40'h12_3456_789a;
        @(posedge mclk);
        ba_n <= 1'b0;
        setup(3'h4, 12'h400, s, 8'h09);
        run(2);
        cells(c);
        cmp("bypass cells", s, c);
        cmp("bypass oe", 40'h0, {a_oe, b_oe, active});
        @(posedge mclk);
        ba_n <= 1'b1;
        setup(3'h4, 12'h400, s, 8'h0a);
        run(2);
        cells(c);
        cmp("other instr", s, c);
        wr(8'h00, {16'h0, 8'h09, 8'h04});
        ctl.idle(1'b0);
        ctl.steps(2);
        cells(c);
        cmp("idle low", s, c);
    endtask
    task automatic print_verdict();
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #3000000;
        err_total++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_decode();
        t_toggle(1'b0);
        t_toggle(1'b1);
        t_pseudo_random_generation();
        t_count();
        t_psa();
        t_bypass();
        print_verdict();
    end
endmodule
